// ==== rtl/auto_seq_defines.vh ====
// Register offsets, field positions, reset values and timing counts of the auto sequencer.
`ifndef AUTO_SEQ_DEFINES_VH
`define AUTO_SEQ_DEFINES_VH
// Word indices (byte address = 4 * index) for the printed tuning locations.
`define IDX_BOFF_TUNE_LOW 16'h2d4e
`define IDX_BOFF_TUNE_HIGH 16'h2d4f
// Byte addresses of registers that have no printed offset.
`define ADDR_TXRX_MODE 18'h00000
`define ADDR_CSMA_CTRL 18'h00004
`define ADDR_TIMER_CTRL 18'h00008
`define ADDR_COMPARE0 18'h0000c
`define ADDR_TIMER_NOW 18'h00010
`define ADDR_COMMAND 18'h00014
`define ADDR_STATUS 18'h00018
`define ADDR_IRQ_STAT 18'h0001c
`define ADDR_IRQ_MASK 18'h00020
// Mode register bits.
`define MODE_RX_AFTER_TX 0
`define MODE_RX_AFTER_RX 1
`define MODE_AUTO_ACK 2
`define MODE_ACK_RECEIVE 3
// CSMA control fields.
`define CSMA_TX_AFTER 0
`define CSMA_BE_LSB 4
// Timer control bits.
`define TIMER_CSMA_TRIG 3
`define TIMER_CMP0_TX 4
`define TIMER_RUN 0
// Command bits.
`define CMD_TX 0
`define CMD_RX 1
`define CMD_CSMA 2
`define CMD_RF_STOP 3
// Interrupt status bits.
`define IRQ_TX_DONE 0
`define IRQ_RX_DONE 1
`define IRQ_CSMA_DONE 2
`define IRQ_BITS 3
// Reset values.
`define TUNE_LOW_RST 8'h01
`define TUNE_HIGH_RST 8'h09
// Time the device waits for an ACK, in microseconds.
`define ACK_WAIT_US 864
`define CLK_MHZ 10
`endif

// ==== rtl/radio_baseband_auto_sequencer.v ====
// Automatic transmit/receive sequencer of a short-range radio baseband.
//
// Contract
// RQ1: Software discards type 000b frames whose destination and source address modes are both 00b.
// RQ2: Software discards type 000b frames with destination mode 01b, 10b or 11b, or source mode 01b.
// RQ3: A match of the timer with timer compare 0 starts CSMA-CA when the trigger is enabled.
// RQ4: The timer trigger needs both timer control bit 3 and the compare-0 transmit trigger bit set.
// RQ5: With minimum backoff exponent 000b software writes f9h and 13h to the two tuning locations.
// RQ6: With any other minimum backoff exponent the tuning locations must hold 01h and 09h.
// RQ7: After reset the two tuning locations hold 01h and 09h.
// RQ8: Stopping RF during transmit, receive or CCA may still raise a related interrupt afterwards.
// RQ9: Software masks the transmit, receive, filter, CCA and overrun interrupts before stopping RF.
// RQ10: With receive after transmit the device goes idle then receive after a transmission.
// RQ11: With receive after receive the device goes idle then receive again after a frame.
// RQ12: With auto ACK a frame asking for ACK leads to idle, ACK transmit, idle, then receive if enabled.
// RQ13: With ACK reception and receive after transmit, a frame asking for ACK is followed by ACK receive.
// RQ14: With transmit after CSMA-CA a true result leads to transmit, a false result back to idle.
// RQ15: Transmit complete fires at transmit end, ACK received, ACK timeout, or busy channel.
//
// Register map, by byte address, with data in the low bits of each word.
// 0x00 mode, bits 0 to 3: receive after transmit, after receive, ACK reply, ACK receive.
// 0x04 CSMA control: bit 0 transmits after a free channel, bits 6:4 hold the minimum exponent.
// 0x08 timer control: bit 0 runs the timer, bits 3 and 4 together arm the compare-0 trigger.
// 0x0c holds timer compare 0, and 0x10 reads back the running timer.
// 0x14 takes commands: bit 0 transmit, bit 1 receive, bit 2 CSMA-CA, bit 3 RF stop.
// 0x18 reads the one-hot state in bits 6:0 and the last CSMA-CA result in bit 8.
// 0x1c holds the sticky interrupt flags and 0x20 their mask, in the same layout.
// The two backoff tuning bytes sit at word indices 2d4eh and 2d4fh.
//
// Timing.
// A bus request is answered by ack one cycle later, and ack stands for one cycle.
// Front-end enables follow the state one cycle late, and each activity ends in one idle cycle.
// The interrupt line follows the flags and the mask one cycle late.
//
// Hazards and limits.
// The minimum backoff exponent is only stored; software keeps the tuning bytes to match it.
// A timer match is lost if the sequencer is not idle in that cycle; it is not queued.
// Commands other than RF stop are taken only in idle, and a pending follow-up goes first.
// With nothing pending, a transmit command wins over CSMA-CA, which wins over receive.
// An RF stop aborts any activity at once, so a completion that arrives late still sets a flag.
//
// The implementer's own choice: register access over Wishbone.
`timescale 1ns/1ps
`default_nettype none
`include "auto_seq_defines.vh"
module radio_baseband_auto_sequencer #(
    parameter ACK_WAIT_CYCLES = `ACK_WAIT_US * `CLK_MHZ
) (
    // Clock and reset.
    input wire clk_i,
    input wire rst_i,
    // Wishbone slave.
    input wire cyc_i,
    input wire stb_i,
    input wire we_i,
    input wire [17:0] adr_i,
    input wire [3:0] sel_i,
    input wire [31:0] dat_i,
    output reg [31:0] dat_o,
    output reg ack_o,
    // Radio front end.
    output reg tx_on_o,
    output reg rx_on_o,
    output reg cca_on_o,
    output reg tx_ack_frame_o,
    input wire tx_done_i,
    input wire tx_ack_req_i,
    input wire rx_frame_i,
    input wire rx_ack_req_i,
    input wire rx_is_ack_i,
    input wire cca_done_i,
    input wire cca_clear_i,
    // Interrupt.
    output reg irq_o
);
    // One-hot sequencer states.
    localparam [6:0] S_IDLE = 7'h01;
    localparam [6:0] S_TX = 7'h02;
    localparam [6:0] S_RX = 7'h04;
    localparam [6:0] S_ACK_TX = 7'h08;
    localparam [6:0] S_ACK_RX = 7'h10;
    localparam [6:0] S_CSMA = 7'h20;
    localparam [6:0] S_STOP = 7'h40;
    // Next target after the one-cycle idle gap.
    localparam [2:0] N_NONE = 3'h0;
    localparam [2:0] N_TX = 3'h1;
    localparam [2:0] N_RX = 3'h2;
    localparam [2:0] N_ACK_TX = 3'h3;
    localparam [2:0] N_ACK_RX = 3'h4;

    // Software-visible configuration and flags.
    reg [3:0] mode_reg;
    reg [7:0] csma_reg;
    reg [7:0] timer_ctrl_reg;
    reg [31:0] compare0_reg;
    reg [31:0] timer_reg;
    reg [7:0] tune_low_reg;
    reg [7:0] tune_high_reg;
    reg [`IRQ_BITS-1:0] irq_stat_reg;
    reg [`IRQ_BITS-1:0] irq_mask_reg;
    // Sequencer state, pending follow-up and ACK wait counter.
    reg [6:0] state_reg;
    reg [2:0] pend_reg;
    reg csma_result_reg;
    reg [15:0] wait_reg;
    // Per-source event vectors, merged into one set of flags.
    reg [`IRQ_BITS-1:0] ev_tx, ev_rx, ev_csma;
    wire [`IRQ_BITS-1:0] events;

    // Bus decode: a request is taken once, on the edge that raises ack.
    wire wr = cyc_i & stb_i & we_i & ~ack_o & sel_i[0];
    wire rd_cyc = cyc_i & stb_i & ~ack_o;
    wire [15:0] word = adr_i[17:2];
    wire cmd_wr = wr && (adr_i == `ADDR_COMMAND);
    wire stop_cmd = cmd_wr && dat_i[`CMD_RF_STOP];
    // Compare-0 match starts CSMA-CA only with both enables set.
    wire timer_trig = timer_ctrl_reg[`TIMER_CSMA_TRIG] && timer_ctrl_reg[`TIMER_CMP0_TX]
        && timer_ctrl_reg[`TIMER_RUN] && (timer_reg == compare0_reg); // RQ3 RQ4
    wire csma_start = (cmd_wr && dat_i[`CMD_CSMA]) || timer_trig;

    // Register writes, timer and sticky interrupt flags.
    always @(posedge clk_i) begin
        if (rst_i) begin
            mode_reg <= 4'h0;
            csma_reg <= 8'h00;
            timer_ctrl_reg <= 8'h00;
            compare0_reg <= 32'h00000000;
            timer_reg <= 32'h00000000;
            tune_low_reg <= `TUNE_LOW_RST; // RQ7
            tune_high_reg <= `TUNE_HIGH_RST; // RQ7
            irq_stat_reg <= {`IRQ_BITS{1'b0}};
            irq_mask_reg <= {`IRQ_BITS{1'b0}};
        end else begin
            // The timer counts only while its run bit is set.
            if (timer_ctrl_reg[`TIMER_RUN])
                timer_reg <= timer_reg + 32'h00000001;
            // Configuration writes; unmapped addresses are ignored.
            if (wr) begin
                case (adr_i)
                    `ADDR_TXRX_MODE: mode_reg <= dat_i[3:0];
                    `ADDR_CSMA_CTRL: csma_reg <= dat_i[7:0];
                    `ADDR_TIMER_CTRL: timer_ctrl_reg <= dat_i[7:0];
                    `ADDR_COMPARE0: compare0_reg <= dat_i;
                    `ADDR_IRQ_MASK: irq_mask_reg <= dat_i[`IRQ_BITS-1:0];
                    default: ;
                endcase
                // The tuning bytes sit far above the other registers.
                if (word == `IDX_BOFF_TUNE_LOW && adr_i[1:0] == 2'b00)
                    tune_low_reg <= dat_i[7:0];
                if (word == `IDX_BOFF_TUNE_HIGH && adr_i[1:0] == 2'b00)
                    tune_high_reg <= dat_i[7:0];
            end
            // Write one to clear; a new event in the same cycle wins.
            if (wr && adr_i == `ADDR_IRQ_STAT)
                irq_stat_reg <= (irq_stat_reg & ~dat_i[`IRQ_BITS-1:0]) | events;
            else
                irq_stat_reg <= irq_stat_reg | events;
        end
    end

    // Read data and acknowledge, one cycle after the strobe.
    always @(posedge clk_i) begin
        if (rst_i) begin
            ack_o <= 1'b0;
            dat_o <= 32'h00000000;
        end else begin
            ack_o <= rd_cyc;
            dat_o <= 32'h00000000;
            if (rd_cyc && !we_i) begin
                case (adr_i)
                    `ADDR_TXRX_MODE: dat_o <= {28'h0000000, mode_reg};
                    `ADDR_CSMA_CTRL: dat_o <= {24'h000000, csma_reg};
                    `ADDR_TIMER_CTRL: dat_o <= {24'h000000, timer_ctrl_reg};
                    `ADDR_COMPARE0: dat_o <= compare0_reg;
                    `ADDR_TIMER_NOW: dat_o <= timer_reg;
                    `ADDR_STATUS: dat_o <= {23'h000000, csma_result_reg, 1'b0, state_reg};
                    `ADDR_IRQ_STAT: dat_o <= {29'h00000000, irq_stat_reg};
                    `ADDR_IRQ_MASK: dat_o <= {29'h00000000, irq_mask_reg};
                    // Tuning bytes, otherwise an unmapped read that answers zero.
                    default: begin
                        if (word == `IDX_BOFF_TUNE_LOW && adr_i[1:0] == 2'b00)
                            dat_o <= {24'h000000, tune_low_reg};
                        else if (word == `IDX_BOFF_TUNE_HIGH && adr_i[1:0] == 2'b00)
                            dat_o <= {24'h000000, tune_high_reg};
                    end
                endcase
            end
        end
    end

    // Events raised by the sequencer in this cycle.
    always @* begin
        ev_tx = {`IRQ_BITS{1'b0}};
        ev_rx = {`IRQ_BITS{1'b0}};
        ev_csma = {`IRQ_BITS{1'b0}};
        case (state_reg)
            // A transmit that moves on to an ACK wait reports at the end of that wait.
            S_TX: if (tx_done_i && !(tx_ack_req_i && mode_reg[`MODE_ACK_RECEIVE]
                    && mode_reg[`MODE_RX_AFTER_TX]))
                ev_tx[`IRQ_TX_DONE] = 1'b1; // RQ15
            S_ACK_TX: if (tx_done_i)
                ev_tx[`IRQ_TX_DONE] = 1'b1;
            S_ACK_RX: if ((rx_frame_i && rx_is_ack_i) || wait_reg == 16'h0000)
                ev_tx[`IRQ_TX_DONE] = 1'b1; // RQ15
            S_RX: if (rx_frame_i)
                ev_rx[`IRQ_RX_DONE] = 1'b1;
            S_CSMA: if (cca_done_i) begin
                ev_csma[`IRQ_CSMA_DONE] = 1'b1;
                if (!cca_clear_i)
                    ev_tx[`IRQ_TX_DONE] = 1'b1; // RQ15
            end
            // A stop may still let a late completion through.
            S_STOP: begin
                ev_tx[`IRQ_TX_DONE] = tx_done_i; // RQ8
                ev_rx[`IRQ_RX_DONE] = rx_frame_i; // RQ8
                ev_csma[`IRQ_CSMA_DONE] = cca_done_i; // RQ8
            end
            default: ;
        endcase
    end
    assign events = ev_tx | ev_rx | ev_csma;

    // Sequencer: every activity ends in a one-cycle idle gap.
    always @(posedge clk_i) begin
        if (rst_i) begin
            state_reg <= S_IDLE;
            pend_reg <= N_NONE;
            csma_result_reg <= 1'b0;
            wait_reg <= 16'h0000;
        end else if (stop_cmd) begin
            state_reg <= S_STOP;
            pend_reg <= N_NONE;
        end else begin
            case (state_reg)
                // Idle: a pending follow-up first, then a fresh command or timer match.
                S_IDLE: begin
                    pend_reg <= N_NONE;
                    if (pend_reg == N_TX || (pend_reg == N_NONE && cmd_wr && dat_i[`CMD_TX]))
                        state_reg <= S_TX;
                    else if (pend_reg == N_RX)
                        state_reg <= S_RX;
                    else if (pend_reg == N_ACK_TX)
                        state_reg <= S_ACK_TX;
                    else if (pend_reg == N_ACK_RX) begin
                        state_reg <= S_ACK_RX;
                        wait_reg <= ACK_WAIT_CYCLES[15:0];
                    end else if (csma_start)
                        state_reg <= S_CSMA;
                    else if (cmd_wr && dat_i[`CMD_RX])
                        state_reg <= S_RX;
                end
                // A sent frame asking for ACK leads to the ACK wait when both modes allow it.
                S_TX: if (tx_done_i) begin
                    state_reg <= S_IDLE;
                    if (tx_ack_req_i && mode_reg[`MODE_ACK_RECEIVE] && mode_reg[`MODE_RX_AFTER_TX])
                        pend_reg <= N_ACK_RX; // RQ13
                    else if (mode_reg[`MODE_RX_AFTER_TX])
                        pend_reg <= N_RX; // RQ10
                end
                // A received frame asking for ACK leads to the ACK reply first when auto ACK is set.
                S_RX: if (rx_frame_i) begin
                    state_reg <= S_IDLE;
                    if (rx_ack_req_i && mode_reg[`MODE_AUTO_ACK])
                        pend_reg <= N_ACK_TX; // RQ12
                    else if (mode_reg[`MODE_RX_AFTER_RX])
                        pend_reg <= N_RX; // RQ11
                end
                // After the ACK reply the receiver comes back only if enabled.
                S_ACK_TX: if (tx_done_i) begin
                    state_reg <= S_IDLE;
                    if (mode_reg[`MODE_RX_AFTER_RX])
                        pend_reg <= N_RX; // RQ12
                end
                // The ACK wait ends on an ACK frame or when the counter runs out.
                S_ACK_RX: begin
                    wait_reg <= wait_reg - 16'h0001;
                    if ((rx_frame_i && rx_is_ack_i) || wait_reg == 16'h0000)
                        state_reg <= S_IDLE; // RQ13
                end
                // A free channel may queue a transmit; a busy one just returns to idle.
                S_CSMA: if (cca_done_i) begin
                    state_reg <= S_IDLE;
                    csma_result_reg <= cca_clear_i;
                    if (cca_clear_i && csma_reg[`CSMA_TX_AFTER])
                        pend_reg <= N_TX; // RQ14
                end
                // RF stop lasts one cycle, then idle.
                S_STOP: state_reg <= S_IDLE;
                default: state_reg <= S_IDLE;
            endcase
        end
    end

    // Front-end enables and interrupt line, all registered.
    always @(posedge clk_i) begin
        if (rst_i) begin
            tx_on_o <= 1'b0;
            rx_on_o <= 1'b0;
            cca_on_o <= 1'b0;
            tx_ack_frame_o <= 1'b0;
            irq_o <= 1'b0;
        end else begin
            tx_on_o <= (state_reg == S_TX) || (state_reg == S_ACK_TX);
            rx_on_o <= (state_reg == S_RX) || (state_reg == S_ACK_RX);
            cca_on_o <= (state_reg == S_CSMA);
            tx_ack_frame_o <= (state_reg == S_ACK_TX);
            irq_o <= |(irq_stat_reg & irq_mask_reg);
        end
    end
endmodule
`default_nettype wire

// ==== testbench/auto_seq_properties.sv ====
// Concurrent checks on the ports of the auto sequencer.
`timescale 1ns/1ps
`default_nettype none
module auto_seq_properties (
    // Clock, reset and bus.
    input wire logic clk_i, rst_i, cyc_i, stb_i, we_i,
    input wire logic [17:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i, dat_o,
    input wire logic ack_o, irq_o,
    // Radio side.
    input wire logic tx_on_o, rx_on_o, cca_on_o, tx_ack_frame_o,
    input wire logic tx_done_i, tx_ack_req_i, rx_frame_i, rx_ack_req_i,
    input wire logic rx_is_ack_i, cca_done_i, cca_clear_i
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // The bus answers one cycle after a request, for one cycle, and reads zero between.
    a_ack_one_cycle: assert property (ack_o |=> !ack_o) else $error("ack held");
    a_ack_after_req: assert property (cyc_i && stb_i && !ack_o |=> ack_o) else $error("no ack");
    a_dat_zero_idle: assert property (!ack_o |-> dat_o == 32'h0) else $error("dat_o set");
    // Only one radio activity at a time, with an idle cycle before receive.
    a_one_activity: assert property ($onehot0({tx_on_o, rx_on_o, cca_on_o}))
        else $error("two activities");
    a_idle_before_rx: assert property ($rose(rx_on_o) |-> !$past(tx_on_o))
        else $error("no idle gap");
    a_ack_frame_tx: assert property (tx_ack_frame_o |-> tx_on_o) else $error("ack off tx");
    // Each activity ends soon after its completion pulse.
    a_tx_end: assert property (tx_on_o && tx_done_i |-> ##[1:3] !tx_on_o)
        else $error("tx stays");
    a_rx_end: assert property (rx_on_o && rx_frame_i |-> ##[1:3] !rx_on_o)
        else $error("rx stays");
    a_cca_end: assert property (cca_on_o && cca_done_i |-> ##[1:3] !cca_on_o)
        else $error("cca stays");
endmodule
`default_nettype wire

// ==== testbench/radio_peer_model.sv ====
// Behavioural remote radio node answering the sequencer's enables.
`timescale 1ns/1ps
`default_nettype none
module radio_peer_model (
    // Clock, reset and scenario controls.
    input wire logic clk_i, rst_i, want_ack_i, rx_go_i, clear_i, is_ack_i,
    // Sequencer enables.
    input wire logic tx_on_i, rx_on_i, cca_on_i,
    // Answers to the sequencer.
    output logic tx_done_o, tx_ack_req_o, rx_frame_o, rx_ack_req_o,
    output logic rx_is_ack_o, cca_done_o, cca_clear_o
);
    logic [2:0] cnt;
    wire logic hit = cnt == 3'h4;
    // Each transmit and CCA ends four cycles in, a receive only with rx_go_i; qualifiers toggle outside the pulse.
    always @(posedge clk_i) begin
        cnt <= (rst_i || !(tx_on_i || rx_on_i || cca_on_i)) ? 3'h0 : cnt + 3'h1;
        tx_done_o <= hit && tx_on_i && !rst_i;
        // Frames sent are data or ACK frames, never of type 000b, so software keeps them.
        rx_frame_o <= hit && rx_on_i && rx_go_i && !rst_i;
        cca_done_o <= hit && cca_on_i && !rst_i;
        tx_ack_req_o <= !rst_i && (hit ? want_ack_i : !tx_ack_req_o);
        rx_ack_req_o <= !rst_i && (hit ? want_ack_i : !rx_ack_req_o);
        rx_is_ack_o <= !rst_i && (hit ? is_ack_i : !rx_is_ack_o);
        cca_clear_o <= !rst_i && (hit ? clear_i : !cca_clear_o);
    end
endmodule
`default_nettype wire

// ==== testbench/tb_top.sv ====
// Self-checking bench for the auto sequencer with a behavioural radio peer.
`timescale 1ns/1ps
`default_nettype none
`include "auto_seq_defines.vh"
module tb_top;
    logic clk_i = 1'h0, rst_i = 1'h1, cyc_i = 1'h0, stb_i = 1'h0, we_i = 1'h0;
    logic [17:0] adr_i = 18'h0;
    logic [3:0] sel_i = 4'hf;
    logic [31:0] dat_i = 32'h0, dat_o, q;
    logic ack_o, tx_on_o, rx_on_o, cca_on_o, tx_ack_frame_o, irq_o, tx_done_i, tx_ack_req_i;
    logic rx_frame_i, rx_ack_req_i, rx_is_ack_i, cca_done_i, cca_clear_i;
    logic want_ack = 1'h0, rx_go = 1'h0, clear = 1'h0, is_ack = 1'h0;
    int num_errors = 0, comparisons = 0;
    // Index 0 ack frame, 1 tx, 2 rx, 3 cca, 4 irq.
    wire logic [4:0] mon = {irq_o, cca_on_o, rx_on_o, tx_on_o, tx_ack_frame_o};
    localparam logic [17:0] T_LO = {`IDX_BOFF_TUNE_LOW, 2'h0};
    localparam logic [17:0] T_HI = {`IDX_BOFF_TUNE_HIGH, 2'h0};
    typedef struct packed {logic w; logic [17:0] a; logic [31:0] d;} row_t;
    row_t rows [7];
    radio_baseband_auto_sequencer #(.ACK_WAIT_CYCLES(20)) u_dut (.clk_i(clk_i), .rst_i(rst_i),
        .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i),
        .dat_o(dat_o), .ack_o(ack_o), .tx_on_o(tx_on_o), .rx_on_o(rx_on_o), .cca_on_o(cca_on_o),
        .tx_ack_frame_o(tx_ack_frame_o), .tx_done_i(tx_done_i), .tx_ack_req_i(tx_ack_req_i),
        .rx_frame_i(rx_frame_i), .rx_ack_req_i(rx_ack_req_i), .rx_is_ack_i(rx_is_ack_i),
        .cca_done_i(cca_done_i), .cca_clear_i(cca_clear_i), .irq_o(irq_o));
    radio_peer_model u_peer (.clk_i(clk_i), .rst_i(rst_i), .want_ack_i(want_ack),
        .rx_go_i(rx_go), .clear_i(clear), .is_ack_i(is_ack), .tx_on_i(tx_on_o),
        .rx_on_i(rx_on_o),
        .cca_on_i(cca_on_o), .tx_done_o(tx_done_i), .tx_ack_req_o(tx_ack_req_i),
        .rx_frame_o(rx_frame_i), .rx_ack_req_o(rx_ack_req_i), .rx_is_ack_o(rx_is_ack_i),
        .cca_done_o(cca_done_i), .cca_clear_o(cca_clear_i));
    // Prints the verdict and ends the run.
    task finish_test;
        if (num_errors == 0 && comparisons > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    // Compares one value and counts it.
    task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
        comparisons++;
        if (g !== e) begin
            num_errors++;
            $display("CHECK FAILED %s exp %h got %h", s, e, g);
        end
    endtask
    // Waits, bounded, for a monitored output to reach a level.
    task automatic wt(input int i, input logic v);
        int n;
        n = 0;
        while (mon[i] !== v && n < 300) begin
            @(posedge clk_i);
            n++;
        end
        if (n == 300) begin
            chk("wait", v, mon[i]);
            finish_test;
        end
    endtask
    // One classic Wishbone cycle, held until ack is sampled.
    task automatic wb(input logic w, input logic [17:0] a, input logic [31:0] d,
        output logic [31:0] r);
        int n;
        n = 0;
        cyc_i <= 1'h1;
        stb_i <= 1'h1;
        we_i <= w;
        adr_i <= a;
        dat_i <= d;
        @(posedge clk_i);
        while (ack_o !== 1'h1 && n < 50) begin
            @(posedge clk_i);
            n++;
        end
        if (n == 50) begin
            chk("ack", 1'h1, ack_o);
            finish_test;
        end
        r = dat_o;
        cyc_i <= 1'h0;
        stb_i <= 1'h0;
        @(posedge clk_i);
    endtask
    initial forever #50 clk_i = ~clk_i;
    initial begin
        rows = '{'{1'h0, T_LO, 32'h1}, '{1'h0, T_HI, 32'h9}, '{1'h1, T_LO, 32'hf9},
            '{1'h1, T_HI, 32'h13}, '{1'h0, T_LO, 32'hf9}, '{1'h0, T_HI, 32'h13},
            '{1'h0, 18'h00100, 32'h0}};
        repeat (10) @(posedge clk_i);
        rst_i <= 1'h0;
        @(posedge clk_i);
        foreach (rows[i]) begin
            wb(rows[i].w, rows[i].a, rows[i].d, q);
            if (!rows[i].w) chk("table read", rows[i].d, q);
        end
        // Transmit, then receive on its own; interrupt raised, masked and cleared.
        wb(1'h1, `ADDR_TXRX_MODE, 32'h1, q);
        wb(1'h1, `ADDR_COMMAND, 32'h1, q);
        wt(1, 1'h1);
        wt(2, 1'h1);
        chk("tx off in rx", 1'h0, tx_on_o);
        wb(1'h0, `ADDR_IRQ_STAT, 32'h0, q);
        chk("tx irq", 32'h1, q);
        chk("irq masked", 1'h0, irq_o);
        wb(1'h1, `ADDR_IRQ_MASK, 32'h1, q);
        wt(4, 1'h1);
        wb(1'h1, `ADDR_IRQ_STAT, 32'h7, q);
        wt(4, 1'h0);
        wb(1'h1, `ADDR_IRQ_MASK, 32'h0, q);
        wb(1'h1, `ADDR_COMMAND, 32'h8, q);
        wt(2, 1'h0);
        chk("irq after stop", 1'h0, irq_o);
        // Received frame asking for ACK: ACK sent, then receive again.
        wb(1'h1, `ADDR_TXRX_MODE, 32'h6, q);
        want_ack <= 1'h1;
        rx_go <= 1'h1;
        wb(1'h1, `ADDR_COMMAND, 32'h2, q);
        wt(0, 1'h1);
        wt(0, 1'h0);
        wt(2, 1'h1);
        rx_go <= 1'h0;
        wb(1'h1, `ADDR_COMMAND, 32'h8, q);
        wt(2, 1'h0);
        // Transmit asking for ACK; the ACK never comes and the wait ends in idle.
        wb(1'h1, `ADDR_TXRX_MODE, 32'h9, q);
        wb(1'h1, `ADDR_COMMAND, 32'h1, q);
        wt(2, 1'h1);
        wt(2, 1'h0);
        wb(1'h0, `ADDR_STATUS, 32'h0, q);
        chk("idle after ack wait", 32'h1, q);
        // The same transmit, now answered by an ACK well before the wait runs out.
        wb(1'h1, `ADDR_IRQ_STAT, 32'h7, q);
        rx_go <= 1'h1;
        is_ack <= 1'h1;
        wb(1'h1, `ADDR_COMMAND, 32'h1, q);
        wt(2, 1'h1);
        repeat (8) @(posedge clk_i);
        chk("ack ends wait", 1'h0, rx_on_o);
        wb(1'h0, `ADDR_IRQ_STAT, 32'h0, q);
        chk("ack irq", 32'h1, q);
        rx_go <= 1'h0;
        is_ack <= 1'h0;
        // CSMA-CA with a busy channel, then with a free one.
        want_ack <= 1'h0;
        wb(1'h1, `ADDR_TXRX_MODE, 32'h0, q);
        wb(1'h1, `ADDR_CSMA_CTRL, 32'h1, q);
        wb(1'h1, `ADDR_COMMAND, 32'h4, q);
        wt(3, 1'h1);
        wt(3, 1'h0);
        repeat (6) @(posedge clk_i);
        chk("no tx after busy", 1'h0, tx_on_o);
        clear <= 1'h1;
        wb(1'h1, `ADDR_COMMAND, 32'h4, q);
        wt(1, 1'h1);
        wt(1, 1'h0);
        // Timer compare 0 starts CSMA-CA.
        wb(1'h1, `ADDR_COMPARE0, 32'h40, q);
        wb(1'h1, `ADDR_TIMER_CTRL, 32'h19, q);
        wt(3, 1'h1);
        // Reset in mid-run: enables drop and the tuning bytes return to their reset values.
        rst_i <= 1'h1;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'h0;
        @(posedge clk_i);
        chk("outputs after reset", 32'h0, mon);
        wb(1'h0, T_LO, 32'h0, q);
        chk("tune low after reset", 32'h1, q);
        wb(1'h0, T_HI, 32'h0, q);
        chk("tune high after reset", 32'h9, q);
        wb(1'h1, `ADDR_CSMA_CTRL, 32'h31, q);
        wb(1'h0, `ADDR_CSMA_CTRL, 32'h0, q);
        chk("csma control", 32'h31, q);
        finish_test;
    end
endmodule
bind radio_baseband_auto_sequencer auto_seq_properties u_chk (.clk_i(clk_i), .rst_i(rst_i),
    .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i),
    .dat_o(dat_o), .ack_o(ack_o), .irq_o(irq_o), .tx_on_o(tx_on_o), .rx_on_o(rx_on_o),
    .cca_on_o(cca_on_o), .tx_ack_frame_o(tx_ack_frame_o), .tx_done_i(tx_done_i),
    .tx_ack_req_i(tx_ack_req_i), .rx_frame_i(rx_frame_i), .rx_ack_req_i(rx_ack_req_i),
    .rx_is_ack_i(rx_is_ack_i), .cca_done_i(cca_done_i), .cca_clear_i(cca_clear_i));
`default_nettype wire
